/* src/bank_decoder_defs.vh */
// Purpose: Constants for the banked data memory decoder
// Assumes: Included by bare name from every design file
// Notes: Register indexes 0, 3 and 4 are printed offsets, index 5 is the decode register; byte address is index * 4
`ifndef BANK_DECODER_DEFS_VH
`define BANK_DECODER_DEFS_VH

// ****************************************
// Register file offsets within a bank
// ****************************************
`define OFF_INDIRECT 7'h00
`define OFF_STATUS 7'h03
`define OFF_POINTER 7'h04
`define OFF_GPR_BASE 7'h20
`define OFF_BANK1_PRIVATE_END 7'h3F

// ****************************************
// Status register fields and reset values
// ****************************************
`define STATUS_BANK_HIGH 6
`define STATUS_BANK_LOW 5
`define STATUS_INDIRECT_BANK 7
`define STATUS_RESET 8'h00
`define POINTER_RESET 8'h00

// ****************************************
// Bank codes
// ****************************************
`define BANK0 2'h0
`define BANK1 2'h1
`define BANK2 2'h2
`define BANK3 2'h3

// ****************************************
// Bus register indexes and responses
// ****************************************
`define IDX_INDIRECT 4'h0
`define IDX_STATUS 4'h3
`define IDX_POINTER 4'h4
`define IDX_DECODE 4'h5
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ****************************************
// Storage geometry
// ****************************************
`define GPR_DEPTH 128
`define GPR_BANK1_BASE 7'h60

`endif

/* src/gpr_ram.v */
// Purpose: General purpose static RAM, 128 bytes
// Assumes: One access per cycle, write on clock, read combinational
// Notes: Contents are not cleared by reset
`timescale 1ns/10ps
`include "bank_decoder_defs.vh"

module gpr_ram (
  input wire aclk,
  input wire we,
  input wire [6:0] addr,
  input wire [7:0] wdata,
  output wire [7:0] rdata
);

  reg [7:0] mem [0:`GPR_DEPTH-1];

  always @(posedge aclk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  assign rdata = mem[addr];

endmodule

/* src/axi_lite_reg_slave.v */
// Purpose: AXI4-Lite slave turning bus transfers into register accesses
// Assumes: One write and one read under way at most
// Notes: Access held until acc_ack; write wins over read
`timescale 1ns/10ps
`include "bank_decoder_defs.vh"

module axi_lite_reg_slave (
  input wire aclk,
  input wire aresetn,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output wire acc_wr,
  output wire acc_rd,
  output wire [3:0] acc_index,
  output wire [7:0] acc_wdata,
  input wire acc_ack,
  input wire acc_err,
  input wire [7:0] acc_rdata
);

  reg aw_full;
  reg w_full;
  reg ar_full;
  reg [3:0] aw_index;
  reg [3:0] ar_index;
  reg [7:0] w_byte;
  reg w_lane0;
  reg bad_addr_w;
  reg bad_addr_r;

  assign s_axi_awready = !aw_full && !s_axi_bvalid;
  assign s_axi_wready = !w_full && !s_axi_bvalid;
  assign s_axi_arready = !ar_full && !s_axi_rvalid;
  // Bad address or lane 0 off: answered here, storage left alone
  wire skip_wr = aw_full && w_full && (bad_addr_w || !w_lane0);
  wire skip_rd = ar_full && bad_addr_r;
  wire wr_fail = bad_addr_w || (acc_wr && acc_err);
  wire rd_fail = bad_addr_r || (acc_rd && acc_err);
  assign acc_wr = aw_full && w_full && !bad_addr_w && w_lane0;
  assign acc_rd = ar_full && !bad_addr_r && !acc_wr;
  assign acc_index = acc_wr ? aw_index : ar_index;
  assign acc_wdata = w_byte;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      ar_full <= 1'b0;
      aw_index <= 4'h0;
      ar_index <= 4'h0;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
      bad_addr_w <= 1'b0;
      bad_addr_r <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full <= 1'b1;
        aw_index <= s_axi_awaddr[5:2];
        bad_addr_w <= (s_axi_awaddr[31:6] != 26'h0000000);
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full <= 1'b1;
        w_byte <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end
      if (s_axi_arvalid && s_axi_arready) begin
        ar_full <= 1'b1;
        ar_index <= s_axi_araddr[5:2];
        bad_addr_r <= (s_axi_araddr[31:6] != 26'h0000000);
      end
      if ((acc_wr && acc_ack) || skip_wr) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_fail ? `RESP_SLVERR : `RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if ((acc_rd && acc_ack) || skip_rd) begin
        ar_full <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= rd_fail ? `RESP_SLVERR : `RESP_OKAY;
        s_axi_rdata <= rd_fail ? 32'h00000000 : {24'h000000, acc_rdata};
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

/* src/banked_data_memory_decoder.v */
// Purpose: Decode banked data memory accesses from core and bus
// Assumes: Core signals come from logic on aclk, no synchroniser
// Notes:
// Notes on behaviour
// - Two select bits choose one of four banks
// - Status bits 6 and 5 select bank
// - Seven-bit offset joins bank into full address
// - Low offsets special registers, upper offsets RAM
// - Status and pointer reachable in every bank
// - Direct or pointer-indirect access to every location
`timescale 1ns/10ps
`include "bank_decoder_defs.vh"

module banked_data_memory_decoder (
  input wire aclk,
  input wire aresetn,
  input wire core_req,
  input wire core_we,
  input wire [6:0] core_offset,
  input wire [7:0] core_wdata,
  output reg core_ack,
  output reg [7:0] core_rdata,
  output wire sfr_req,
  output wire sfr_we,
  output wire [8:0] sfr_addr,
  output wire [7:0] sfr_wdata,
  input wire [7:0] sfr_rdata,
  output wire [1:0] bank_select,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready
);

  // ****************************************
  // Target codes
  // ****************************************
  localparam T_NONE = 3'h0;
  localparam T_STATUS = 3'h1;
  localparam T_POINTER = 3'h2;
  localparam T_SFR = 3'h3;
  localparam T_RAM = 3'h4;

  // ****************************************
  // Core registers
  // ****************************************
  reg [7:0] core_status_flags;
  reg [7:0] file_select_pointer;
  reg [1:0] last_bank;
  reg [2:0] last_target;

  wire bank_select_high = core_status_flags[`STATUS_BANK_HIGH];
  wire bank_select_low = core_status_flags[`STATUS_BANK_LOW];
  assign bank_select = {bank_select_high, bank_select_low};

  // ****************************************
  // Bus slave
  // ****************************************
  wire bus_wr;
  wire bus_rd;
  wire [3:0] bus_index;
  wire [7:0] bus_wdata;
  wire bus_ack;
  wire bus_err;
  reg [7:0] bus_rdata;

  axi_lite_reg_slave i_axi_lite_reg_slave (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .acc_wr(bus_wr),
    .acc_rd(bus_rd),
    .acc_index(bus_index),
    .acc_wdata(bus_wdata),
    .acc_ack(bus_ack),
    .acc_err(bus_err),
    .acc_rdata(bus_rdata)
  );

  // ****************************************
  // Access arbitration: core first
  // ****************************************
  wire bus_pending = bus_wr || bus_rd;
  wire bus_grant = bus_pending && !core_req;
  assign bus_ack = bus_grant;

  reg bus_map_ok;
  reg [6:0] bus_offset;

  always @* begin
    bus_map_ok = 1'b1;
    bus_offset = `OFF_INDIRECT;
    case (bus_index)
      `IDX_INDIRECT: bus_offset = `OFF_INDIRECT;
      `IDX_STATUS: bus_offset = `OFF_STATUS;
      `IDX_POINTER: bus_offset = `OFF_POINTER;
      `IDX_DECODE: bus_offset = `OFF_INDIRECT;
      default: bus_map_ok = 1'b0;
    endcase
  end

  wire bus_decode_reg = (bus_index == `IDX_DECODE);
  assign bus_err = !bus_map_ok || (bus_wr && bus_decode_reg);

  wire acc_valid = core_req || (bus_grant && bus_map_ok && !bus_decode_reg);
  wire acc_we = core_req ? core_we : (bus_wr && !bus_err);
  wire [6:0] acc_offset = core_req ? core_offset : bus_offset;
  wire [7:0] acc_wdata = core_req ? core_wdata : bus_wdata;

  // ****************************************
  // Address formation
  // ****************************************
  wire use_pointer = (acc_offset == `OFF_INDIRECT);
  wire [8:0] direct_addr = {bank_select, acc_offset};
  wire [8:0] indirect_addr =
    {core_status_flags[`STATUS_INDIRECT_BANK], file_select_pointer};
  wire [8:0] full_addr = use_pointer ? indirect_addr : direct_addr;
  wire [1:0] eff_bank = full_addr[8:7];
  wire [6:0] eff_off = full_addr[6:0];

  // ****************************************
  // Target decode
  // ****************************************
  reg [2:0] target;
  reg [6:0] ram_addr;

  always @* begin
    target = T_NONE;
    ram_addr = eff_off - `OFF_GPR_BASE;
    if (eff_off == `OFF_INDIRECT) begin
      target = T_NONE;
    end else if (eff_off == `OFF_STATUS) begin
      target = T_STATUS;
    end else if (eff_off == `OFF_POINTER) begin
      target = T_POINTER;
    end else if (eff_off < `OFF_GPR_BASE) begin
      target = T_SFR;
    end else begin
      target = T_RAM;
      case (eff_bank)
        `BANK1: begin
          if (eff_off <= `OFF_BANK1_PRIVATE_END) begin
            ram_addr = eff_off + `GPR_BANK1_BASE - `OFF_GPR_BASE;
          end
        end
        `BANK0: ram_addr = eff_off - `OFF_GPR_BASE;
        default: ram_addr = eff_off - `OFF_GPR_BASE;
      endcase
    end
  end

  // ****************************************
  // Storage and peripheral register port
  // ****************************************
  wire [7:0] ram_rdata;
  wire ram_we = acc_valid && acc_we && (target == T_RAM);

  gpr_ram i_gpr_ram (
    .aclk(aclk),
    .we(ram_we),
    .addr(ram_addr),
    .wdata(acc_wdata),
    .rdata(ram_rdata)
  );

  assign sfr_req = acc_valid && (target == T_SFR);
  assign sfr_we = acc_we;
  assign sfr_addr = full_addr;
  assign sfr_wdata = acc_wdata;

  reg [7:0] acc_rdata;

  always @* begin
    case (target)
      T_STATUS: acc_rdata = core_status_flags;
      T_POINTER: acc_rdata = file_select_pointer;
      T_SFR: acc_rdata = sfr_rdata;
      T_RAM: acc_rdata = ram_rdata;
      default: acc_rdata = 8'h00;
    endcase
  end

  always @* begin
    if (bus_decode_reg) begin
      bus_rdata = {3'h0, last_target, last_bank};
    end else begin
      bus_rdata = acc_rdata;
    end
  end

  // ****************************************
  // Register updates and core answer
  // ****************************************
  wire acc_wr_now = acc_valid && acc_we;

  always @(posedge aclk) begin
    if (!aresetn) begin
      core_status_flags <= `STATUS_RESET;
      file_select_pointer <= `POINTER_RESET;
      last_bank <= `BANK0;
      last_target <= T_NONE;
      core_ack <= 1'b0;
      core_rdata <= 8'h00;
    end else begin
      if (acc_wr_now && target == T_STATUS) begin
        core_status_flags <= acc_wdata;
      end
      if (acc_wr_now && target == T_POINTER) begin
        file_select_pointer <= acc_wdata;
      end
      if (acc_valid) begin
        last_bank <= eff_bank;
        last_target <= target;
      end
      core_ack <= core_req;
      if (core_req && !core_we) begin
        core_rdata <= acc_rdata;
      end
    end
  end

endmodule

/* tb/decoder_asserts.sv */
// Purpose: Assertions on the core side of the decoder
// Assumes: Bound to banked_data_memory_decoder
// Notes: Core access answered one cycle after its request
`timescale 1ns/10ps
module decoder_asserts (
  input wire aclk,
  input wire aresetn,
  input wire core_req,
  input wire core_we,
  input wire [6:0] core_offset,
  input wire [7:0] core_wdata,
  input wire core_ack,
  input wire [7:0] core_rdata,
  input wire sfr_req,
  input wire sfr_we,
  input wire [8:0] sfr_addr,
  input wire [7:0] sfr_wdata,
  input wire [1:0] bank_select
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ack_follows_req_a:
  assert property (core_req |=> core_ack) else $error("no core answer");
  ack_has_cause_a:
  assert property (core_ack |-> $past(core_req)) else $error("stray answer");
  bank_from_status_a:
  assert property (core_req && core_we && core_offset == 7'h03
    |=> bank_select == $past(core_wdata[6:5])) else $error("bank bits");
  direct_addr_a:
  assert property (core_req && core_offset != 7'h00
    |-> sfr_addr == {bank_select, core_offset}) else $error("full address");
  ram_not_sfr_a:
  assert property (core_req && core_offset >= 7'h20 |-> !sfr_req)
    else $error("ram offset hit peripheral");
  sfr_decode_a:
  assert property (core_req && core_offset inside {[7'h01:7'h1F]}
    && !(core_offset inside {7'h03, 7'h04})
    |-> sfr_req && sfr_we == core_we && sfr_wdata == core_wdata)
    else $error("peripheral decode");
  core_regs_local_a:
  assert property (core_req && core_offset inside {7'h03, 7'h04} |-> !sfr_req)
    else $error("status or pointer sent out");
  status_mirror_a:
  assert property (core_req && !core_we && core_offset == 7'h03
    |=> core_rdata[6:5] == $past(bank_select)) else $error("status read");
endmodule
bind banked_data_memory_decoder decoder_asserts i_decoder_asserts (
  .aclk(aclk), .aresetn(aresetn), .core_req(core_req), .core_we(core_we),
  .core_offset(core_offset), .core_wdata(core_wdata), .core_ack(core_ack),
  .core_rdata(core_rdata), .sfr_req(sfr_req), .sfr_we(sfr_we),
  .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .bank_select(bank_select));

/* tb/core_model.sv */
// Purpose: Processor core issuing data memory accesses
// Assumes: One access at a time, answer one cycle later
// Notes: Write data shows its inverse once released
`timescale 1ns/10ps
module core_model (
  input wire aclk,
  output logic core_req,
  output logic core_we,
  output logic [6:0] core_offset,
  output logic [7:0] core_wdata,
  input wire core_ack,
  input wire [7:0] core_rdata
);
  initial begin
    core_req = 1'b0;
    core_we = 1'b0;
    core_offset = 7'h7F;
    core_wdata = 8'hFF;
  end
  task access(input logic we, input logic [6:0] off, input logic [7:0] wd,
    output logic ack, output logic [7:0] rd);
    @(posedge aclk);
    core_req <= 1'b1;
    core_we <= we;
    core_offset <= off;
    core_wdata <= wd;
    @(posedge aclk);
    core_req <= 1'b0;
    core_wdata <= ~wd;
    #1;
    ack = core_ack;
    rd = core_rdata;
  endtask
endmodule

/* tb/banked_data_memory_decoder_test.sv */
// Purpose: Self-checking bench for the banked decoder
// Assumes: Core model on the core port, bench as bus master
// Notes: Peripheral read data derived from the low eight bits of the full address
`timescale 1ns/10ps
`include "bank_decoder_defs.vh"
module banked_data_memory_decoder_test;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] awaddr, wdata, araddr;
  wire awready, wready, bvalid, arready, rvalid;
  wire core_req, core_we, core_ack, sfr_req, sfr_we;
  wire [1:0] bresp, rresp, bank_select;
  wire [31:0] rdata;
  wire [6:0] core_offset;
  wire [7:0] core_wdata, core_rdata, sfr_wdata, sfr_rdata;
  wire [8:0] sfr_addr;
  int checked = 0;
  int n_mismatch = 0;
  int b;
  // Peripheral stand-in
  assign sfr_rdata = sfr_addr[7:0] ^ 8'h5A;
  core_model i_core_model (.aclk(aclk), .core_req(core_req),
    .core_we(core_we), .core_offset(core_offset), .core_wdata(core_wdata),
    .core_ack(core_ack), .core_rdata(core_rdata));
  banked_data_memory_decoder i_banked_data_memory_decoder (.aclk(aclk),
    .aresetn(aresetn), .core_req(core_req), .core_we(core_we),
    .core_offset(core_offset), .core_wdata(core_wdata),
    .core_ack(core_ack), .core_rdata(core_rdata), .sfr_req(sfr_req),
    .sfr_we(sfr_we), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .bank_select(bank_select),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task test_done;
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task hang;
    chk(32'h0, 32'h1);
    test_done;
  endtask
  task axi_wr(input logic [31:0] a, input logic [31:0] d,
    input logic [1:0] r);
    bit done;
    done = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 100 && !done; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        bready <= 1'b0;
        done = 1;
        chk(bresp, r);
      end
    end
    if (!done) hang;
  endtask
  task axi_rd(input logic [31:0] a, input logic [31:0] d,
    input logic [1:0] r);
    bit done;
    done = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 100 && !done; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        rready <= 1'b0;
        done = 1;
        chk(rdata, d);
        chk(rresp, r);
      end
    end
    if (!done) hang;
  endtask
  task cacc(input logic we, input logic [6:0] off, input logic [7:0] wd,
    input logic [7:0] exp);
    logic ack;
    logic [7:0] rd;
    i_core_model.access(we, off, wd, ack, rd);
    chk(ack, 1);
    if (!we) chk(rd, exp);
  endtask
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, wdata, araddr} = 96'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(32'h0C, 32'h00, `RESP_OKAY);
    axi_rd(32'h10, 32'h00, `RESP_OKAY);
    axi_rd(32'h1C, 32'h00, `RESP_SLVERR);
    axi_wr(32'h14, 32'h00, `RESP_SLVERR);
    $display("test reset done");
    for (b = 0; b < 4; b++) begin
      axi_wr(32'h0C, b << 5, `RESP_OKAY);
      chk(bank_select, b);
      cacc(0, `OFF_STATUS, 8'h00, 8'(b << 5));
      cacc(1, 7'h30, 8'(8'h40 + b), 8'h00);
    end
    for (b = 0; b < 4; b++) begin
      axi_wr(32'h0C, b << 5, `RESP_OKAY);
      cacc(0, 7'h30, 8'h00, b == 1 ? 8'h41 : 8'h43);
    end
    axi_wr(32'h0C, 32'h20, `RESP_OKAY);
    cacc(1, 7'h50, 8'hA5, 8'h00);
    cacc(1, 7'h3F, 8'h3C, 8'h00);
    cacc(1, 7'h40, 8'h4D, 8'h00);
    axi_wr(32'h0C, 32'h00, `RESP_OKAY);
    cacc(0, 7'h50, 8'h00, 8'hA5);
    cacc(0, 7'h40, 8'h00, 8'h4D);
    cacc(1, 7'h3F, 8'hC3, 8'h00);
    $display("test banks done");
    cacc(1, `OFF_POINTER, 8'hBF, 8'h00);
    cacc(0, `OFF_INDIRECT, 8'h00, 8'h3C);
    cacc(0, 7'h3F, 8'h00, 8'hC3);
    cacc(1, `OFF_POINTER, 8'h35, 8'h00);
    axi_rd(32'h10, 32'h35, `RESP_OKAY);
    cacc(1, `OFF_INDIRECT, 8'h77, 8'h00);
    cacc(0, 7'h35, 8'h00, 8'h77);
    axi_rd(32'h00, 32'h77, `RESP_OKAY);
    cacc(1, `OFF_POINTER, 8'h00, 8'h00);
    cacc(0, `OFF_INDIRECT, 8'h00, 8'h00);
    $display("test indirect done");
    cacc(1, `OFF_STATUS, 8'h40, 8'h00);
    chk(bank_select, 2);
    cacc(1, 7'h06, 8'h3C, 8'h00);
    cacc(0, 7'h06, 8'h00, 8'h5C);
    cacc(0, `OFF_POINTER, 8'h00, 8'h00);
    axi_rd(32'h14, 32'h0A, `RESP_OKAY);
    axi_wr(32'h4C, 32'h60, `RESP_SLVERR);
    chk(bank_select, 2);
    axi_rd(32'h4C, 32'h00, `RESP_SLVERR);
    $display("test peripheral done");
    test_done;
  end
endmodule
